// file: hdl/rsrpc_top.sv
// serial register bus slave with strength readout, power, channel and test clock control
`timescale 1ns/1ps
`include "rsrpc_defs.svh"
// Overview of operation
// [RULE1] strength reads as 6-bit raw value in bits 15:10, about 1 dB/step
// [RULE2] host reads strength only after receive enabled and synthesizer settled
// [RULE3] synthesizer-locked flag readable at bit 12 of synth status
// [RULE4] sync-found flag readable at bit 7 of link status
// [RULE5] strength follows any energy, valid without a sync word
// [RULE6] strength-disable bit 9 turns measurement off, saving current
// [RULE7] host disables measurement, reads value, then re-enables for next reading
// [RULE8] transmit power register value selects power code, revision-specific upper bits
// [RULE9] read-only silicon identity register for choosing power codes
// [RULE10] active-low reset returns configuration registers to defaults
// [RULE11] packet indicator pin driven, also readable in link status
// [RULE12] fifo threshold pin only asserts for packets beyond 63 bytes
// [RULE13] test clock output routed by 3-bit select field
// [RULE14] channel register: channel 6:0, receive enable bit 7, transmit bit 8
// [RULE15] host treats strength field as unsigned, ignoring low ten bits
module rsrpc_top #(
  parameter logic [15:0] SILICON_ID = 16'h0a5a, // arbitrary identity value
  parameter int TCLK_MAX_DIV = 7
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic reset_n_pin_in,
  // serial register bus
  input wire logic spi_sel_n_in,
  input wire logic spi_sclk_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  // radio core status
  input wire rsrpc_pkg::rsrpc_radio_t radio_in,
  input wire logic [7:0] rx_byte_count_in,
  // radio core control
  output logic [6:0] channel_out,
  output logic rx_enable_out,
  output logic tx_enable_out,
  output logic [15:0] tx_power_out,
  output logic strength_enable_out,
  // indicator and test pins
  output logic packet_indicator_pin_out,
  output logic fifo_flag_out,
  output logic bare_die_test_clock_out
);
  // pin synchronisers: sel, sclk, mosi, reset pin
  logic [3:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic sclk_d_reg, sclk_d_next;
  rsrpc_pkg::rsrpc_state_t state_reg, state_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] addr_sh_reg, addr_sh_next;
  logic [15:0] data_sh_reg, data_sh_next;
  logic [15:0] chan_op_reg, chan_op_next;
  logic [15:0] tx_power_reg, tx_power_next;
  logic [15:0] strength_ctrl_reg, strength_ctrl_next;
  logic [15:0] test_clk_reg, test_clk_next;
  logic [5:0] strength_hold_reg, strength_hold_next;
  logic [2:0] tdiv_reg, tdiv_next;
  logic tclk_reg, tclk_next;
  logic miso_reg, miso_next, oe_reg, oe_next;
  logic pkt_reg, pkt_next, fifo_reg, fifo_next;
  logic sel_n, sclk, mosi, rst_pin_n, cfg_rst, rise, fall;
  logic [15:0] rd_data;

  assign sel_n = sync2_reg[0];
  assign sclk = sync2_reg[1];
  assign mosi = sync2_reg[2];
  assign rst_pin_n = sync2_reg[3];
  assign rise = sclk & ~sclk_d_reg;
  assign fall = ~sclk & sclk_d_reg;
  assign cfg_rst = rst_in | ~rst_pin_n; // [RULE10]

  // read mux over the register map
  always_comb begin
    rd_data = 16'h0000;
    case (addr_sh_reg[6:0])
      `RSRPC_ADDR_SYNTH_STATUS: rd_data[`RSRPC_LOCK_BIT] = radio_in.synth_locked; // [RULE3]
      `RSRPC_ADDR_STRENGTH: rd_data[15:`RSRPC_STRENGTH_LSB] = strength_hold_reg; // [RULE1]
      `RSRPC_ADDR_CHAN_OP: rd_data = chan_op_reg;
      `RSRPC_ADDR_TX_POWER: rd_data = tx_power_reg;
      `RSRPC_ADDR_STRENGTH_CTRL: rd_data = strength_ctrl_reg;
      `RSRPC_ADDR_SILICON_ID: rd_data = SILICON_ID; // [RULE9]
      `RSRPC_ADDR_TEST_CLK: rd_data = test_clk_reg;
      `RSRPC_ADDR_LINK_STATUS: begin
        rd_data[`RSRPC_SYNC_BIT] = radio_in.sync_found; // [RULE4]
        rd_data[`RSRPC_PKT_BIT] = pkt_reg; // [RULE11]
      end
      default: rd_data = 16'h0000;
    endcase
  end

  // synchronisers and bus sequencing
  always_comb begin
    sync1_next = {reset_n_pin_in, spi_mosi_in, spi_sclk_in, spi_sel_n_in};
    sync2_next = sync1_reg;
    sclk_d_next = sclk;
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    addr_sh_next = addr_sh_reg;
    data_sh_next = data_sh_reg;
    miso_next = miso_reg;
    oe_next = ~sel_n;
    chan_op_next = chan_op_reg;
    tx_power_next = tx_power_reg;
    strength_ctrl_next = strength_ctrl_reg;
    test_clk_next = test_clk_reg;
    if (sel_n) begin
      state_next = rsrpc_pkg::RSRPC_ADDR;
      bit_cnt_next = 5'h00;
      miso_next = 1'b0;
    end else begin
      case (state_reg)
        rsrpc_pkg::RSRPC_ADDR: begin
          if (rise) begin
            addr_sh_next = {addr_sh_reg[6:0], mosi};
            bit_cnt_next = bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'h07) begin
              state_next = rsrpc_pkg::RSRPC_DATA;
              bit_cnt_next = 5'h00;
            end
          end
        end
        rsrpc_pkg::RSRPC_DATA: begin
          if (fall && bit_cnt_reg == 5'h00) begin
            data_sh_next = rd_data;
            miso_next = rd_data[15];
          end else if (fall) begin
            miso_next = data_sh_reg[15];
          end
          if (rise) begin
            data_sh_next = {data_sh_reg[14:0], mosi};
            bit_cnt_next = bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'h0f) begin
              state_next = rsrpc_pkg::RSRPC_IDLE;
              if (!addr_sh_reg[7]) begin
                case (addr_sh_reg[6:0])
                  `RSRPC_ADDR_CHAN_OP: chan_op_next = {data_sh_reg[14:0], mosi}; // [RULE14]
                  `RSRPC_ADDR_TX_POWER: tx_power_next = {data_sh_reg[14:0], mosi}; // [RULE8]
                  `RSRPC_ADDR_STRENGTH_CTRL: strength_ctrl_next = {data_sh_reg[14:0], mosi}; // [RULE6]
                  `RSRPC_ADDR_TEST_CLK: test_clk_next = {data_sh_reg[14:0], mosi};
                  default: chan_op_next = chan_op_reg;
                endcase
              end
            end
          end
        end
        default: state_next = state_reg;
      endcase
    end
  end

  // strength capture, indicators and test clock divider
  always_comb begin
    strength_hold_next = strength_hold_reg;
    if (!strength_ctrl_reg[`RSRPC_DISABLE_BIT] && chan_op_reg[`RSRPC_RX_EN_BIT])
      strength_hold_next = radio_in.strength; // [RULE5] [RULE6] [RULE7]
    pkt_next = radio_in.packet_done;
    fifo_next = radio_in.fifo_level && (rx_byte_count_in > 8'(`RSRPC_FIFO_THRESH_BYTES)); // [RULE12]
    tdiv_next = tdiv_reg + 3'h1;
    tclk_next = tclk_reg;
    if (test_clk_reg[`RSRPC_TCLK_SEL_LSB +: 3] == 3'h0) begin // [RULE13]
      tdiv_next = 3'h0;
      tclk_next = 1'b0;
    end else if (tdiv_reg >= test_clk_reg[`RSRPC_TCLK_SEL_LSB +: 3] || tdiv_reg >= 3'(TCLK_MAX_DIV)) begin
      tdiv_next = 3'h0;
      tclk_next = ~tclk_reg;
    end
  end

  // registers
  always_ff @(posedge ref_clk_in) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
    if (rst_in) begin
      // idle pin levels: reset pin high, mosi high, sclk low, select high (no false sclk edge)
      sync1_reg <= 4'hd;
      sync2_reg <= 4'hd;
      sclk_d_reg <= 1'b0;
      state_reg <= rsrpc_pkg::RSRPC_IDLE;
      bit_cnt_reg <= 5'h00;
      addr_sh_reg <= 8'h00;
      data_sh_reg <= 16'h0000;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
      pkt_reg <= 1'b0;
      fifo_reg <= 1'b0;
      tdiv_reg <= 3'h0;
      tclk_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      addr_sh_reg <= addr_sh_next;
      data_sh_reg <= data_sh_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
      pkt_reg <= pkt_next;
      fifo_reg <= fifo_next;
      tdiv_reg <= tdiv_next;
      tclk_reg <= tclk_next;
    end
    if (cfg_rst) begin // [RULE10]
      chan_op_reg <= `RSRPC_CHAN_OP_RST;
      tx_power_reg <= `RSRPC_TX_POWER_RST;
      strength_ctrl_reg <= `RSRPC_STRENGTH_CTRL_RST;
      test_clk_reg <= `RSRPC_TEST_CLK_RST;
      strength_hold_reg <= 6'h00;
    end else begin
      chan_op_reg <= chan_op_next;
      tx_power_reg <= tx_power_next;
      strength_ctrl_reg <= strength_ctrl_next;
      test_clk_reg <= test_clk_next;
      strength_hold_reg <= strength_hold_next;
    end
  end

  // outputs from flops
  assign spi_miso_out = miso_reg;
  assign spi_miso_oe_out = oe_reg;
  assign channel_out = chan_op_reg[6:0];
  assign rx_enable_out = chan_op_reg[`RSRPC_RX_EN_BIT];
  assign tx_enable_out = chan_op_reg[`RSRPC_TX_EN_BIT];
  assign tx_power_out = tx_power_reg;
  assign strength_enable_out = ~strength_ctrl_reg[`RSRPC_DISABLE_BIT];
  assign packet_indicator_pin_out = pkt_reg; // [RULE11]
  assign fifo_flag_out = fifo_reg;
  assign bare_die_test_clock_out = tclk_reg;
endmodule : rsrpc_top

// file: hdl/rsrpc_defs.svh
// register offsets, field positions and reset values for the strength/power block
`ifndef RSRPC_DEFS_SVH
`define RSRPC_DEFS_SVH
`define RSRPC_ADDR_SYNTH_STATUS 7'h03
`define RSRPC_ADDR_STRENGTH 7'h06
`define RSRPC_ADDR_CHAN_OP 7'h07
`define RSRPC_ADDR_TX_POWER 7'h09
`define RSRPC_ADDR_STRENGTH_CTRL 7'h0b
`define RSRPC_ADDR_SILICON_ID 7'h1f
`define RSRPC_ADDR_TEST_CLK 7'h20
`define RSRPC_ADDR_LINK_STATUS 7'h30
`define RSRPC_LOCK_BIT 12
`define RSRPC_STRENGTH_LSB 10
`define RSRPC_SYNC_BIT 7
`define RSRPC_PKT_BIT 6
`define RSRPC_DISABLE_BIT 9
`define RSRPC_RX_EN_BIT 7
`define RSRPC_TX_EN_BIT 8
`define RSRPC_TCLK_SEL_LSB 1
`define RSRPC_TX_POWER_RST 16'h1820
`define RSRPC_STRENGTH_CTRL_RST 16'h0008
`define RSRPC_CHAN_OP_RST 16'h0000
`define RSRPC_TEST_CLK_RST 16'h0000
`define RSRPC_FIFO_THRESH_BYTES 63
`endif

// file: hdl/rsrpc_pkg.sv
// types shared by the strength/power block
package rsrpc_pkg;
  typedef enum logic [1:0] {
    RSRPC_IDLE = 2'b00,
    RSRPC_ADDR = 2'b01,
    RSRPC_DATA = 2'b10
  } rsrpc_state_t;
  typedef struct packed {
    logic synth_locked;
    logic sync_found;
    logic packet_done;
    logic fifo_level;
    logic [5:0] strength;
  } rsrpc_radio_t;
endpackage : rsrpc_pkg

// file: verif/rsrpc_checker.sv
// port checker for the strength/power block
`timescale 1ns/1ps
module rsrpc_checker (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic reset_n_pin_in,
  input wire logic spi_sel_n_in,
  input wire rsrpc_pkg::rsrpc_radio_t radio_in,
  input wire logic [7:0] rx_byte_count_in,
  input wire logic spi_miso_oe_out,
  input wire logic [6:0] channel_out,
  input wire logic [15:0] tx_power_out,
  input wire logic strength_enable_out,
  input wire logic packet_indicator_pin_out,
  input wire logic fifo_flag_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  chk_pkt_pin: assert property (!$past(rst_in) |->
    packet_indicator_pin_out == $past(radio_in.packet_done))
    else $error("packet pin not following core");
  chk_fifo_flag: assert property (!$past(rst_in) |->
    fifo_flag_out == $past(radio_in.fifo_level && rx_byte_count_in > 8'h3f))
    else $error("fifo flag wrong");
  chk_fifo_short: assert property (rx_byte_count_in <= 8'h3f |=> !fifo_flag_out)
    else $error("fifo flag on short packet");
  chk_reset_vals: assert property ($fell(rst_in) |-> tx_power_out == 16'h1820 && strength_enable_out)
    else $error("reset values wrong");
  chk_pin_reset: assert property (!reset_n_pin_in [*6] |->
    tx_power_out == 16'h1820 && channel_out == 7'h00)
    else $error("pin reset not applied");
  chk_oe_idle: assert property (spi_sel_n_in [*5] |-> !spi_miso_oe_out)
    else $error("data out driven while idle");
  chk_oe_frame: assert property (!spi_sel_n_in [*5] |-> spi_miso_oe_out)
    else $error("data out not driven in frame");
  chk_regs_stand: assert property ((spi_sel_n_in && reset_n_pin_in) [*6] |->
    $stable(tx_power_out) && $stable(channel_out) && $stable(strength_enable_out))
    else $error("config changed without frame");
endmodule : rsrpc_checker
bind rsrpc_top rsrpc_checker chk (.ref_clk_in, .rst_in, .reset_n_pin_in, .spi_sel_n_in, .radio_in,
  .rx_byte_count_in, .spi_miso_oe_out, .channel_out, .tx_power_out, .strength_enable_out,
  .packet_indicator_pin_out, .fifo_flag_out);

// file: verif/rsrpc_host.sv
// serial bus host model driving register frames
`timescale 1ns/1ps
module rsrpc_host (
  input wire logic ref_clk_in,
  input wire logic miso_in,
  output logic sel_n_out,
  output logic sclk_out,
  output logic mosi_out
);
  // idle bus, clock stands low
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : wait_n
  // address byte then word, msb first, read bits taken late in high phase
  task automatic xfer(input logic [7:0] addr, input logic [15:0] wdata, output logic [15:0] rdata);
    logic [23:0] sh;
    sh = {addr, wdata};
    rdata = 16'h0000;
    wait_n(1);
    sel_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi_out = sh[i];
      wait_n(4);
      sclk_out = 1'b1;
      wait_n(4);
      if (i < 16) rdata[i] = miso_in;
      sclk_out = 1'b0;
    end
    wait_n(4);
    mosi_out = ~mosi_out; // released line shows no stale bit
    sel_n_out = 1'b1;
    wait_n(6);
  endtask : xfer
endmodule : rsrpc_host

// file: verif/tb_rsrpc_top.sv
// self-checking bench for the strength/power block
`timescale 1ns/1ps
module tb_rsrpc_top;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, reset_n_pin_in = 1'b1;
  logic sel_n, sclk, mosi, miso, oe, tx_en, rx_en, str_en, pkt, fifo, tclk, t;
  logic [6:0] chan;
  logic [7:0] cnt = 8'h00;
  logic [15:0] pwr, rd;
  logic [15:0] pw [5] = '{16'h1820, 16'h1920, 16'h1a20, 16'h1c20, 16'h1e20};
  rsrpc_pkg::rsrpc_radio_t radio = '0;
  int num_errors = 0, comparisons = 0, cycles = 0, n;
  localparam logic [15:0] ID = 16'h3c69; // arbitrary identity value
  rsrpc_top #(.SILICON_ID(ID)) uut (.ref_clk_in, .rst_in, .reset_n_pin_in, .spi_sel_n_in(sel_n),
    .spi_sclk_in(sclk), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe), .radio_in(radio),
    .rx_byte_count_in(cnt), .channel_out(chan), .rx_enable_out(rx_en), .tx_enable_out(tx_en), .tx_power_out(pwr),
    .strength_enable_out(str_en), .packet_indicator_pin_out(pkt), .fifo_flag_out(fifo), .bare_die_test_clock_out(tclk));
  rsrpc_host host (.ref_clk_in, .miso_in(miso), .sel_n_out(sel_n), .sclk_out(sclk), .mosi_out(mosi));
  // clock and cycle ceiling
  initial forever #10 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host.xfer({1'b0, a}, d, rd);
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [15:0] exp, input logic [15:0] mask);
    host.xfer({1'b1, a}, 16'h0000, rd);
    cmp("reg", exp & mask, rd & mask);
  endtask : rdc
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // test sequence
  initial begin
    repeat (8) @(negedge ref_clk_in);
    rst_in = 1'b0;
    host.wait_n(4);
    rdc(7'h09, 16'h1820, 16'hffff);
    rdc(7'h0b, 16'h0008, 16'hffff);
    cmp("str_en", 16'h0001, {15'h0, str_en});
    $display("reset test done");
    foreach (pw[i]) begin
      wr(7'h09, pw[i]);
      rdc(7'h09, pw[i], 16'hffff);
      cmp("tx_power", pw[i], pwr);
    end
    wr(7'h1f, 16'h0000);
    rdc(7'h1f, ID, 16'hffff);
    rdc(7'h15, 16'h0000, 16'hffff);
    $display("power test done");
    for (int v = 0; v < 2; v++) begin
      radio = {v[0], v[0], v[0], 1'b1, 6'h2b};
      cnt = v[0] ? 8'h40 : 8'h3f; // fifo threshold edge
      rdc(7'h03, {3'h0, v[0], 12'h000}, 16'h1000);
      rdc(7'h30, {8'h00, v[0], v[0], 6'h00}, 16'h00c0);
      cmp("pkt_pin", {15'h0, v[0]}, {15'h0, pkt});
      cmp("fifo_flag", {15'h0, v[0]}, {15'h0, fifo});
    end
    $display("status test done");
    radio = {1'b1, 3'h0, 6'h2b}; // carrier only, no sync word
    wr(7'h07, 16'h00a7);
    cmp("chan_op", 16'h00a7, {7'h00, tx_en, rx_en, chan});
    rdc(7'h03, 16'h1000, 16'h1000);
    wr(7'h0b, 16'h0208);
    cmp("str_en", 16'h0000, {15'h0, str_en});
    radio.strength = 6'h05;
    rdc(7'h06, 16'hac00, 16'hfc00);
    wr(7'h0b, 16'h0008);
    rdc(7'h06, 16'h1400, 16'hfc00);
    wr(7'h07, 16'h0127);
    rdc(7'h07, 16'h0127, 16'hffff);
    cmp("chan_op", 16'h0127, {7'h00, tx_en, rx_en, chan});
    $display("strength test done");
    wr(7'h20, 16'h0004);
    n = 0;
    repeat (30) begin
      t = tclk;
      @(negedge ref_clk_in);
      n += int'(t != tclk);
    end
    cmp("tclk_toggles", 16'h000a, n[15:0]);
    wr(7'h20, 16'h0000);
    cmp("tclk_idle", 16'h0000, {15'h0, tclk});
    $display("test clock test done");
    reset_n_pin_in = 1'b0;
    host.wait_n(8);
    reset_n_pin_in = 1'b1;
    host.wait_n(4);
    cmp("pin_rst", 16'h1820, pwr);
    rdc(7'h07, 16'h0000, 16'hffff);
    $display("pin reset test done");
    wrap_up();
  end
endmodule : tb_rsrpc_top
